// [edpc_pkg.sv]
// Package: register map, field positions, reset values and timing for energy-detect power control
package edpc_pkg;

    localparam logic [4:0]  REG_ENERGY_SENSE_CONTROL = 5'h1d;

    localparam int          BIT_ENABLE      = 15;
    localparam int          BIT_AUTO_WAKE   = 14;
    localparam int          BIT_AUTO_SLEEP  = 13;
    localparam int          BIT_MANUAL      = 12;
    localparam int          BIT_BURST_DIS   = 11;
    localparam int          BIT_PWR_STATE   = 10;
    localparam int          BIT_ERR_HIT     = 9;
    localparam int          BIT_DATA_HIT    = 8;
    localparam int          ERR_THR_LSB     = 4;
    localparam int          DATA_THR_LSB    = 0;

    localparam logic [3:0]  ERR_THR_RESET   = 4'h1;
    localparam logic [3:0]  DATA_THR_RESET  = 4'h1;
    localparam logic        AUTO_WAKE_RESET = 1'b1;
    localparam logic        AUTO_SLEEP_RESET = 1'b1;

    localparam int          PULSE_BURST_LEN = 4;
    localparam longint      CLK_HZ          = 25000000;
    localparam longint      QUIET_TIME_MS   = 2000;
    localparam longint      QUIET_CYCLES    = (QUIET_TIME_MS * CLK_HZ) / 1000;
    localparam int          PULSE_GAP_CYCLES = 8;

    typedef struct packed {
        logic       enable;
        logic       auto_wake;
        logic       auto_sleep;
        logic       burst_disable;
        logic [3:0] err_thr;
        logic [3:0] data_thr;
    } edpc_cfg_type;

    typedef enum logic [1:0] {
        PWR_UP    = 2'b00,
        PWR_DOWN  = 2'b01,
        PWR_WAKE  = 2'b11
    } edpc_state_type;

endpackage

// [edpc_pulse_burst.sv]
// Pulse burst generator: one or a burst of energy-detect pulses per start
`timescale 1ns/100ps
module edpc_pulse_burst
    import edpc_pkg::*;
#(
    parameter int BURST = PULSE_BURST_LEN,
    parameter int GAP   = PULSE_GAP_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic start,
    input  wire logic single,
    output logic      pulse,
    output logic      busy
);
    logic [3:0] left_q, left_d;
    logic [7:0] gap_q,  gap_d;
    logic       pulse_q, pulse_d;

    always_comb begin
        left_d  = left_q;
        gap_d   = gap_q;
        pulse_d = 1'b0;
        if (start) begin
            left_d = single ? 4'h1 : 4'(BURST);
            gap_d  = 8'h0;
        end else if (left_q != 4'h0) begin
            if (gap_q == 8'h0) begin
                pulse_d = 1'b1;
                left_d  = left_q - 4'h1;
                gap_d   = 8'(GAP);
            end else begin
                gap_d = gap_q - 8'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            left_q  <= 4'h0;
            gap_q   <= 8'h0;
            pulse_q <= 1'b0;
        end else begin
            left_q  <= left_d;
            gap_q   <= gap_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse = pulse_q;
    assign busy  = (left_q != 4'h0);

    a_single_one_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        start && single |=> (left_q == 4'h1)) else $error("single burst not one pulse");
    a_burst_four_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        start && !single |=> (left_q == 4'(BURST))) else $error("burst length wrong");
endmodule

// [edpc_energy_power.sv]
// Energy-detect power manager: control register, event counters, power state
`timescale 1ns/100ps
// Functional notes
// - Energy detection operates only while the enable bit 15 is set, which resets to zero.
// - With auto wake (bit 14) set, power-up starts when data events reach the data threshold.
// - With auto sleep (bit 13) set, power-down starts when no energy is on the line.
// - Writing one to self-clearing bit 12 toggles power state at once, ignoring thresholds.
// - Each power-up while enabled sends four pulses, or one when burst disable bit 11 is set.
// - Bit 10 reads one when powered up and enabled, zero when powered down or disabled.
// - Bit 9 sets when error events meet the error threshold, no action, clears on read.
// - Bit 8 sets when data events meet or exceed the data threshold, clears on read.
// - Bits 7:4 hold the error threshold, reset to one.
// - Bits 3:0 hold the data threshold, reset to one.
// - Event counters reset after about two seconds without a data event.
module edpc_energy_power
    import edpc_pkg::*;
#(
    parameter longint QUIET_LIMIT = QUIET_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        reg_sel,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        line_data_event,
    input  wire logic        line_error_event,
    input  wire logic        line_energy,
    output logic             powered_up,
    output logic             tx_energy_pulse
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1_q, sync2_q, sync3_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync3_q <= 3'h0;
        end else begin
            sync1_q <= {line_energy, line_error_event, line_data_event};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    logic data_ev, err_ev, energy_on;
    assign data_ev   = sync2_q[0] & ~sync3_q[0];
    assign err_ev    = sync2_q[1] & ~sync3_q[1];
    assign energy_on = sync2_q[2];

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    edpc_cfg_type   cfg_q, cfg_d;
    logic           manual_q, manual_d;
    logic           err_hit_q, err_hit_d;
    logic           data_hit_q, data_hit_d;
    logic [15:0]    rdata_q, rdata_d;
    edpc_state_type state_q, state_d;
    logic [3:0]     data_cnt_q, data_cnt_d;
    logic [3:0]     err_cnt_q, err_cnt_d;
    logic [31:0]    quiet_q, quiet_d;
    logic           pwr_q, pwr_d;
    logic           burst_start;

    logic wr_hit, rd_hit;
    assign wr_hit = reg_sel && reg_wr;
    assign rd_hit = reg_sel && reg_rd;

    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        sat_inc = (v == 4'hf) ? v : v + 4'h1;
    endfunction

    logic [15:0] cur_word;
    always_comb begin
        cur_word = 16'h0;
        cur_word[BIT_ENABLE]     = cfg_q.enable;
        cur_word[BIT_AUTO_WAKE]  = cfg_q.auto_wake;
        cur_word[BIT_AUTO_SLEEP] = cfg_q.auto_sleep;
        cur_word[BIT_MANUAL]     = manual_q;
        cur_word[BIT_BURST_DIS]  = cfg_q.burst_disable;
        // Meaningless while disabled, so it reads zero then, as after reset
        cur_word[BIT_PWR_STATE]  = pwr_q & cfg_q.enable;
        cur_word[BIT_ERR_HIT]    = err_hit_q;
        cur_word[BIT_DATA_HIT]   = data_hit_q;
        cur_word[ERR_THR_LSB +: 4]  = cfg_q.err_thr;
        cur_word[DATA_THR_LSB +: 4] = cfg_q.data_thr;
    end

    // ------------------------------------------------------------
    // Register file and event counting
    // ------------------------------------------------------------
    logic data_met, err_met, quiet_done;
    assign data_met   = sat_inc(data_cnt_q) >= cfg_q.data_thr;
    assign err_met    = sat_inc(err_cnt_q) >= cfg_q.err_thr;
    assign quiet_done = (quiet_q >= 32'(QUIET_LIMIT - 1));

    always_comb begin
        cfg_d      = cfg_q;
        manual_d   = 1'b0; // Self-clears after one cycle of action
        err_hit_d  = err_hit_q;
        data_hit_d = data_hit_q;
        rdata_d    = rd_hit ? cur_word : 16'h0;
        data_cnt_d = data_cnt_q;
        err_cnt_d  = err_cnt_q;
        quiet_d    = quiet_q;
        if (rd_hit) begin
            err_hit_d  = 1'b0;
            data_hit_d = 1'b0;
        end
        if (wr_hit) begin
            cfg_d.enable        = reg_wdata[BIT_ENABLE];
            cfg_d.auto_wake     = reg_wdata[BIT_AUTO_WAKE];
            cfg_d.auto_sleep    = reg_wdata[BIT_AUTO_SLEEP];
            cfg_d.burst_disable = reg_wdata[BIT_BURST_DIS];
            cfg_d.err_thr       = reg_wdata[ERR_THR_LSB +: 4];
            cfg_d.data_thr      = reg_wdata[DATA_THR_LSB +: 4];
            manual_d            = reg_wdata[BIT_MANUAL];
        end
        if (!cfg_q.enable) begin
            data_cnt_d = 4'h0;
            err_cnt_d  = 4'h0;
            quiet_d    = 32'h0;
            err_hit_d  = 1'b0;
            data_hit_d = 1'b0;
        end else begin
            if (data_ev) begin
                quiet_d    = 32'h0;
                data_cnt_d = sat_inc(data_cnt_q);
                // Set wins over a read clear in the same cycle
                if (data_met) begin
                    data_hit_d = 1'b1;
                end
            end else if (quiet_done) begin
                data_cnt_d = 4'h0;
                err_cnt_d  = 4'h0;
                quiet_d    = 32'h0;
            end else begin
                quiet_d = quiet_q + 32'h1;
            end
            if (err_ev && !(quiet_done && !data_ev)) begin
                err_cnt_d = sat_inc(err_cnt_q);
                if (err_met) begin
                    err_hit_d = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        burst_start = 1'b0;
        case (state_q)
            PWR_UP: begin
                if (!cfg_q.enable) begin
                    state_d = PWR_UP;
                end else if (manual_q) begin
                    state_d = PWR_DOWN;
                end else if (cfg_q.auto_sleep && !energy_on) begin
                    state_d = PWR_DOWN;
                end
            end
            PWR_DOWN: begin
                if (!cfg_q.enable || manual_q) begin
                    state_d = PWR_WAKE;
                end else if (cfg_q.auto_wake && data_ev && data_met) begin
                    state_d = PWR_WAKE;
                end
            end
            PWR_WAKE: begin
                burst_start = cfg_q.enable;
                state_d     = PWR_UP;
            end
            default: state_d = PWR_UP;
        endcase
        pwr_d = (state_d != PWR_DOWN);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q      <= '{enable: 1'b0, auto_wake: AUTO_WAKE_RESET,
                            auto_sleep: AUTO_SLEEP_RESET, burst_disable: 1'b0,
                            err_thr: ERR_THR_RESET, data_thr: DATA_THR_RESET};
            manual_q   <= 1'b0;
            err_hit_q  <= 1'b0;
            data_hit_q <= 1'b0;
            rdata_q    <= 16'h0;
            data_cnt_q <= 4'h0;
            err_cnt_q  <= 4'h0;
            quiet_q    <= 32'h0;
            state_q    <= PWR_UP;
            pwr_q      <= 1'b1;
        end else begin
            cfg_q      <= cfg_d;
            manual_q   <= manual_d;
            err_hit_q  <= err_hit_d;
            data_hit_q <= data_hit_d;
            rdata_q    <= rdata_d;
            data_cnt_q <= data_cnt_d;
            err_cnt_q  <= err_cnt_d;
            quiet_q    <= quiet_d;
            state_q    <= state_d;
            pwr_q      <= pwr_d;
        end
    end

    edpc_pulse_burst u_burst (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (burst_start),
        .single  (cfg_q.burst_disable),
        .pulse   (tx_energy_pulse),
        .busy    ()
    );

    assign reg_rdata  = rdata_q;
    assign powered_up = pwr_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_disabled_held_up: assert property (@(posedge clk) disable iff (!reset_n)
        !cfg_q.enable |=> pwr_q || $past(cfg_q.enable)) else $error("down while disabled");
    a_disabled_flags_low: assert property (@(posedge clk) disable iff (!reset_n)
        !cfg_q.enable |=> !data_hit_q && !err_hit_q && data_cnt_q == 4'h0)
        else $error("flags set while disabled");
    a_manual_self_clear: assert property (@(posedge clk) disable iff (!reset_n)
        manual_q |=> !manual_q) else $error("manual bit stuck");
    a_manual_goes_down: assert property (@(posedge clk) disable iff (!reset_n)
        manual_q && cfg_q.enable && state_q == PWR_UP |=> !pwr_q)
        else $error("manual toggle ignored");
    a_sleep_no_energy: assert property (@(posedge clk) disable iff (!reset_n)
        cfg_q.enable && cfg_q.auto_sleep && state_q == PWR_UP && !energy_on |=> !pwr_q)
        else $error("auto sleep missed");
    a_wake_on_data: assert property (@(posedge clk) disable iff (!reset_n)
        cfg_q.enable && cfg_q.auto_wake && state_q == PWR_DOWN && data_ev && data_met
        |=> pwr_q ##1 pwr_q) else $error("auto wake missed");
    a_data_hit_set: assert property (@(posedge clk) disable iff (!reset_n)
        cfg_q.enable && data_ev && data_met |=> data_hit_q) else $error("data hit lost");
    a_err_hit_set: assert property (@(posedge clk) disable iff (!reset_n)
        cfg_q.enable && err_ev && err_met && (data_ev || !quiet_done) |=> err_hit_q)
        else $error("error hit lost");
    a_read_clears: assert property (@(posedge clk) disable iff (!reset_n)
        rd_hit && !data_ev && !err_ev |=> !data_hit_q && !err_hit_q)
        else $error("read did not clear");
    a_state_readback: assert property (@(posedge clk) disable iff (!reset_n)
        rd_hit |=> reg_rdata[BIT_PWR_STATE] == ($past(pwr_q) && $past(cfg_q.enable)))
        else $error("state readback");
    a_quiet_reset: assert property (@(posedge clk) disable iff (!reset_n)
        cfg_q.enable && quiet_done && !data_ev |=> data_cnt_q == 4'h0)
        else $error("counters not reset");
endmodule

// [edpc_line_partner.sv]
// Line-side link partner model: energy level, data and error events, pulse counter
`timescale 1ns/100ps
module edpc_line_partner (
    input  wire logic clk,
    input  wire logic tx_energy_pulse,
    output logic      line_data_event,
    output logic      line_error_event,
    output logic      line_energy
);
    int pulse_count;

    initial begin
        line_data_event  = 1'b0;
        line_error_event = 1'b0;
        line_energy      = 1'b0;
        pulse_count      = 0;
    end

    // --------------------------------------------------------------
    // Pulses received from the device
    // --------------------------------------------------------------
    always @(posedge clk) begin
        if (tx_energy_pulse === 1'b1) begin
            pulse_count <= pulse_count + 1;
        end
    end

    // --------------------------------------------------------------
    // Line stimulus
    // --------------------------------------------------------------
    task automatic set_energy(input logic lvl);
        @(posedge clk);
        line_energy <= lvl;
    endtask

    // Two cycles high, three low between events, so the synchroniser sees every edge
    task automatic send_event(input bit is_err, input int n);
        repeat (n) begin
            @(posedge clk);
            if (is_err) begin
                line_error_event <= 1'b1;
            end else begin
                line_data_event <= 1'b1;
            end
            repeat (2) @(posedge clk);
            line_error_event <= 1'b0;
            line_data_event  <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule

// [test_edpc_energy_power.sv]
// Testbench for the energy-detect power manager
`timescale 1ns/100ps
module test_edpc_energy_power
    import edpc_pkg::*;
;
    localparam int          QL     = 200;
    localparam logic [15:0] CFG    = 16'he032;
    localparam logic [15:0] M_EN   = 16'h0001 << BIT_ENABLE;
    localparam logic [15:0] M_MAN  = 16'h0001 << BIT_MANUAL;
    localparam logic [15:0] M_BRST = 16'h0001 << BIT_BURST_DIS;
    localparam logic [15:0] M_PWR  = 16'h0001 << BIT_PWR_STATE;
    localparam logic [15:0] M_ERR  = 16'h0001 << BIT_ERR_HIT;
    localparam logic [15:0] M_DATA = 16'h0001 << BIT_DATA_HIT;

    logic        clk;
    logic        reset_n;
    logic        reg_sel;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        line_data_event;
    logic        line_error_event;
    logic        line_energy;
    logic        powered_up;
    logic        tx_energy_pulse;
    int          fail_count;
    int          cmp_count;
    int          cyc;
    int          p0;

    edpc_energy_power #(.QUIET_LIMIT(QL)) dut_u (
        .clk(clk), .reset_n(reset_n), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_data_event(line_data_event),
        .line_error_event(line_error_event), .line_energy(line_energy),
        .powered_up(powered_up), .tx_energy_pulse(tx_energy_pulse));

    edpc_line_partner partner_u (
        .clk(clk), .tx_energy_pulse(tx_energy_pulse), .line_data_event(line_data_event),
        .line_error_event(line_error_event), .line_energy(line_energy));

    // --------------------------------------------------------------
    // Checking and access tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [15:0] d);
        @(posedge clk);
        reg_sel   <= 1'b1;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_sel <= 1'b0;
        reg_wr  <= 1'b0;
    endtask

    // Read data is registered and stands one cycle only
    task automatic chk_reg(input logic [15:0] mask, input logic [15:0] exp, input string msg);
        @(posedge clk);
        reg_sel <= 1'b1;
        reg_rd  <= 1'b1;
        @(posedge clk);
        reg_sel <= 1'b0;
        reg_rd  <= 1'b0;
        @(negedge clk);
        chk(reg_rdata & mask, exp & mask, msg);
    endtask

    task automatic chk_pwr(input logic exp, input string msg);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({15'h0000, powered_up}, {15'h0000, exp}, msg);
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, fail_count);
    endtask

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Clock and hang guard
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            $display("wrong value at %0t: run did not finish", $time);
            complete_run();
        end
    end

    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial begin
        reset_n    = 1'b0;
        reg_sel    = 1'b0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        reg_wdata  = 16'h0000;
        fail_count = 0;
        cmp_count  = 0;
        cyc        = 0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        chk_reg(16'hffff, 16'h6011, "reset image");
        chk_pwr(1'b1, "powered after reset");
        end_test("reset");

        partner_u.send_event(1'b0, 3);
        chk_reg(M_DATA, 16'h0000, "data flag while disabled");
        chk_pwr(1'b1, "power while disabled");
        end_test("disabled");

        reg_write(CFG);
        chk_pwr(1'b0, "auto sleep on quiet line");
        chk_reg(M_PWR, 16'h0000, "state bit when down");
        partner_u.set_energy(1'b1);
        p0 = partner_u.pulse_count;
        partner_u.send_event(1'b0, 1);
        chk_pwr(1'b0, "below data threshold");
        partner_u.send_event(1'b0, 1);
        chk_pwr(1'b1, "auto wake at threshold");
        repeat (60) @(posedge clk);
        @(negedge clk);
        chk(16'(partner_u.pulse_count - p0), 16'h0004, "burst length");
        chk_reg(M_PWR | M_DATA, M_PWR | M_DATA, "state and data flag");
        chk_reg(M_DATA, 16'h0000, "data flag clear on read");
        end_test("auto wake");

        partner_u.send_event(1'b1, 2);
        chk_reg(M_ERR, 16'h0000, "error flag below threshold");
        partner_u.send_event(1'b1, 1);
        chk_reg(M_ERR, M_ERR, "error flag at threshold");
        chk_pwr(1'b1, "no action on errors");
        chk_reg(M_ERR, 16'h0000, "error flag clear on read");
        end_test("error threshold");

        partner_u.set_energy(1'b0);
        chk_pwr(1'b0, "sleep when energy lost");
        partner_u.set_energy(1'b1);
        repeat (QL + 50) @(posedge clk);
        partner_u.send_event(1'b0, 1);
        repeat (QL + 50) @(posedge clk);
        partner_u.send_event(1'b0, 1);
        chk_pwr(1'b0, "count dropped after quiet time");
        partner_u.send_event(1'b0, 1);
        chk_pwr(1'b1, "wake on quick second event");
        end_test("quiet reset");

        // Manual toggles, burst cut to one pulse
        reg_write(CFG | M_MAN | M_BRST);
        chk_pwr(1'b0, "manual power down");
        chk_reg(M_MAN, 16'h0000, "manual bit self clears");
        // Let the burst of the last wake finish before counting afresh
        repeat (40) @(posedge clk);
        p0 = partner_u.pulse_count;
        reg_write(CFG | M_MAN | M_BRST);
        repeat (60) @(posedge clk);
        @(negedge clk);
        chk({15'h0000, powered_up}, 16'h0001, "manual power up");
        chk(16'(partner_u.pulse_count - p0), 16'h0001, "single pulse");
        end_test("manual");

        partner_u.set_energy(1'b0);
        chk_pwr(1'b0, "down before disable");
        reg_write(16'h0000);
        chk_pwr(1'b1, "up once disabled");
        chk_reg(M_EN | M_DATA | M_ERR, 16'h0000, "enable and flags off");
        end_test("disable");
        complete_run();
    end
endmodule
